// ### core/fpe_flash_ctrl.sv
// Flash program/erase control register, interlocks and AXI4-Lite slave
//
// Overview of operation
// - HV set only if program/erase already selected
// - HV drives array and runs pump
// - Margin write ignored while HV is set
// - Setting HV clears margin select
// - Program and erase never both set
// - Block size code selects erase span
// - Latched upper address locates erased block
// - Unprotected array write with erase selected and HV off arms erase of the selected block
// - Divide bit chooses pump clock factor
// - Unused divide bit has no effect
// - Erased reads 0, programmed reads 1
// - Eight-byte pages, 64-byte rows, rows 0-511
// - Program acts on one eight-byte page
// - Select bits choose program, erase, margin
// - Pump clock is VCO divided 2 or 4
// - Protected range clears program/erase select
`timescale 1ns/1ps
`default_nettype none
module fpe_flash_ctrl
    import fpe_pkg::*;
(
    // Clock and reset
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // AXI4-Lite write address and data
    input  wire logic [`FPE_AXI_AW-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    // AXI4-Lite read
    input  wire logic [`FPE_AXI_AW-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // CPU writes into the array space
    input  wire logic                   arr_wr_valid,
    input  wire fpe_addr_t              arr_wr_addr,
    input  wire logic [7:0]             arr_wr_data,
    // PLL clock
    input  wire logic                   pll_vco_clock,
    // Array and pump side
    output logic                        high_voltage_array,
    output logic                        pump_clk,
    output logic                        program_mode,
    output logic                        erase_mode,
    output logic                        margin_mode,
    output logic                        erase_armed,
    output fpe_addr_t                   erase_base,
    output fpe_addr_t                   erase_mask,
    output logic [11:0]                 prog_page,
    output logic [7:0]                  prog_data,
    output logic                        prog_load
);
    // Control bits
    logic      program_select_r, program_select_nxt;
    logic      erase_select_r, erase_select_nxt;
    logic      margin_select_r, margin_select_nxt;
    logic      high_voltage_enable_r, high_voltage_enable_nxt;
    fpe_blk_t  erase_block_size_r;
    logic      pump_clock_divide_r;
    logic      unused_divide_bit_r;
    logic      protect_en_r;
    logic [8:0] protect_row_r;
    logic      protect_hit_r;
    logic      erase_armed_r;
    logic [11:0] prog_page_r;
    logic [7:0]  prog_data_r;
    logic        prog_load_r;

    // Bus slave state
    logic                   awready_r, wready_r, aw_full_r, w_full_r;
    logic [`FPE_AXI_AW-1:0] awaddr_r;
    logic [31:0]            wdata_r;
    logic                   wstrb0_r;
    logic                   bvalid_r, arready_r, rvalid_r;
    logic [1:0]             bresp_r, rresp_r;
    logic [31:0]            rdata_r;
    logic                   do_write, wr_ctrl, wr_prot;
    logic                   arr_accept, prot_hit, erase_capture;
    fpe_addr_t              blk_end;

    function automatic logic known_offset(input logic [`FPE_AXI_AW-1:0] a);
        known_offset = (a == `FPE_OFF_CTRL) || (a == `FPE_OFF_STATUS)
                    || (a == `FPE_OFF_PROTECT);
    endfunction : known_offset

    // ---------------- AXI4-Lite write ----------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b0;
            aw_full_r <= 1'b0;
            awaddr_r  <= '0;
        end else if (s_axi_awvalid && awready_r) begin
            awready_r <= 1'b0;
            aw_full_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
        end else if (do_write) begin
            aw_full_r <= 1'b0;
        end else if (!aw_full_r && !bvalid_r) begin
            awready_r <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_r <= 1'b0;
            w_full_r <= 1'b0;
            wdata_r  <= '0;
            wstrb0_r <= 1'b0;
        end else if (s_axi_wvalid && wready_r) begin
            wready_r <= 1'b0;
            w_full_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb0_r <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_full_r <= 1'b0;
        end else if (!w_full_r && !bvalid_r) begin
            wready_r <= 1'b1;
        end
    end

    assign do_write = aw_full_r && w_full_r && !bvalid_r;
    // Only the lane 0 strobe is checked: a write without lane 0 changes nothing
    assign wr_ctrl  = do_write && wstrb0_r && (awaddr_r == `FPE_OFF_CTRL);
    assign wr_prot  = do_write && wstrb0_r && (awaddr_r == `FPE_OFF_PROTECT);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r  <= `FPE_RESP_OKAY;
        end else if (do_write) begin
            bvalid_r <= 1'b1;
            bresp_r  <= known_offset(awaddr_r) ? `FPE_RESP_OKAY : `FPE_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // ---------------- AXI4-Lite read ----------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rdata_r   <= '0;
            rresp_r   <= `FPE_RESP_OKAY;
        end else if (s_axi_arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rresp_r   <= known_offset(s_axi_araddr) ? `FPE_RESP_OKAY : `FPE_RESP_SLVERR;
            case (s_axi_araddr)
                `FPE_OFF_CTRL:    rdata_r <= {24'h000000, unused_divide_bit_r,
                                              pump_clock_divide_r, erase_block_size_r,
                                              high_voltage_enable_r, margin_select_r,
                                              erase_select_r, program_select_r};
                `FPE_OFF_STATUS:  rdata_r <= {15'h0000, protect_hit_r, erase_armed_r,
                                              erase_base};
                `FPE_OFF_PROTECT: rdata_r <= {15'h0000, protect_en_r, 7'h00,
                                              protect_row_r};
                default:          rdata_r <= 32'h00000000;
            endcase
        end else if (rvalid_r) begin
            if (s_axi_rready) begin
                rvalid_r <= 1'b0;
            end
        end else begin
            arready_r <= 1'b1;
        end
    end

    // ---------------- Array access and protection ----------------
    // Address is taken only while a mode is chosen and before HV comes on
    assign arr_accept    = arr_wr_valid && (program_select_r || erase_select_r)
                        && !high_voltage_enable_r;
    assign blk_end       = program_select_r ? (arr_wr_addr | 15'h0007)
                                            : (arr_wr_addr | fpe_blk_mask(erase_block_size_r));
    // Protected area runs from the chosen row to the top of the array
    assign prot_hit      = arr_accept && protect_en_r
                        && (blk_end[14:6] >= protect_row_r);
    assign erase_capture = arr_accept && erase_select_r && !prot_hit;

    // ---------------- Control register next state ----------------
    always_comb begin
        program_select_nxt      = program_select_r;
        erase_select_nxt        = erase_select_r;
        margin_select_nxt       = margin_select_r;
        high_voltage_enable_nxt = high_voltage_enable_r;
        if (wr_ctrl) begin
            if (wdata_r[`FPE_BIT_PROG] && wdata_r[`FPE_BIT_ERASE]) begin
                // Both requested: the current selection stands
                program_select_nxt = program_select_r;
                erase_select_nxt   = erase_select_r;
            end else begin
                program_select_nxt = wdata_r[`FPE_BIT_PROG];
                erase_select_nxt   = wdata_r[`FPE_BIT_ERASE];
            end
            high_voltage_enable_nxt = wdata_r[`FPE_BIT_HV]
                                   && (program_select_r || erase_select_r);
            margin_select_nxt = wdata_r[`FPE_BIT_MARGIN] && !high_voltage_enable_r;
        end
        if (prot_hit) begin
            program_select_nxt = 1'b0;
            erase_select_nxt   = 1'b0;
        end
        // HV with no operation left would stress the array for nothing
        if (!program_select_nxt && !erase_select_nxt) begin
            high_voltage_enable_nxt = 1'b0;
        end
        if (high_voltage_enable_nxt) begin
            margin_select_nxt = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            program_select_r      <= 1'b0;
            erase_select_r        <= 1'b0;
            margin_select_r       <= 1'b0;
            high_voltage_enable_r <= 1'b0;
            erase_block_size_r    <= '0;
            pump_clock_divide_r   <= 1'b0;
            unused_divide_bit_r   <= 1'b0;
        end else begin
            program_select_r      <= program_select_nxt;
            erase_select_r        <= erase_select_nxt;
            margin_select_r       <= margin_select_nxt;
            high_voltage_enable_r <= high_voltage_enable_nxt;
            if (wr_ctrl) begin
                erase_block_size_r  <= {wdata_r[`FPE_BIT_BLK_HI], wdata_r[`FPE_BIT_BLK_LO]};
                pump_clock_divide_r <= wdata_r[`FPE_BIT_DIV];
                // Stored for read-back only, steers nothing
                unused_divide_bit_r <= wdata_r[`FPE_BIT_DIV_SPARE];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            protect_en_r  <= 1'b0;
            protect_row_r <= `FPE_LAST_ROW;
        end else if (wr_prot) begin
            protect_en_r  <= wdata_r[`FPE_PROT_EN_BIT];
            protect_row_r <= wdata_r[8:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            protect_hit_r <= 1'b0;
        end else if (prot_hit) begin
            protect_hit_r <= 1'b1;
        end else if (wr_ctrl) begin
            protect_hit_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            erase_armed_r <= 1'b0;
        end else if (!erase_select_nxt) begin
            erase_armed_r <= 1'b0;
        end else if (erase_capture) begin
            erase_armed_r <= 1'b1;
        end
    end

    // Program data: a 1 bit programs the cell, an erased cell stays 0
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prog_page_r <= '0;
            prog_data_r <= '0;
            prog_load_r <= 1'b0;
        end else begin
            prog_load_r <= arr_accept && program_select_r && !prot_hit;
            if (arr_accept && program_select_r && !prot_hit) begin
                prog_page_r <= arr_wr_addr[14:3];
                prog_data_r <= arr_wr_data;
            end
        end
    end

    fpe_blk_latch u_blk_latch (
        .aclk    (aclk),
        .aresetn (aresetn),
        .capture (erase_capture),
        .addr    (arr_wr_addr),
        .blk     (erase_block_size_r),
        .base    (erase_base),
        .mask    (erase_mask)
    );

    fpe_pump_div u_pump_div (
        .aclk              (aclk),
        .aresetn           (aresetn),
        .pll_vco_clock     (pll_vco_clock),
        .run               (high_voltage_enable_r),
        .pump_clock_divide (pump_clock_divide_r),
        .pump_clk          (pump_clk)
    );

    assign s_axi_awready      = awready_r;
    assign s_axi_wready       = wready_r;
    assign s_axi_bvalid       = bvalid_r;
    assign s_axi_bresp        = bresp_r;
    assign s_axi_arready      = arready_r;
    assign s_axi_rvalid       = rvalid_r;
    assign s_axi_rdata        = rdata_r;
    assign s_axi_rresp        = rresp_r;
    assign high_voltage_array = high_voltage_enable_r;
    assign program_mode       = program_select_r;
    assign erase_mode         = erase_select_r;
    assign margin_mode        = margin_select_r;
    assign erase_armed        = erase_armed_r;
    assign prog_page          = prog_page_r;
    assign prog_data          = prog_data_r;
    assign prog_load          = prog_load_r;

    // ---------------- Checks ----------------
    hv_needs_op_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(high_voltage_enable_r) |-> $past(program_select_r || erase_select_r))
        else $error("high voltage set with no operation selected");

    margin_refused_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_ctrl && high_voltage_enable_r) |=> !margin_select_r)
        else $error("margin set while high voltage on");

    margin_cleared_a: assert property (@(posedge aclk) disable iff (!aresetn)
        high_voltage_enable_r |-> !margin_select_r)
        else $error("margin and high voltage both set");

    op_interlock_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !(program_select_r && erase_select_r))
        else $error("program and erase both selected");

    protect_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        prot_hit |=> !program_select_r && !erase_select_r && !high_voltage_enable_r
                     && protect_hit_r)
        else $error("protected access kept operation selected");

    erase_arm_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (erase_capture && !wr_ctrl) |=> erase_armed_r ##1 (erase_armed_r || !erase_select_r))
        else $error("array write did not arm erase");

    reset_clear_a: assert property (@(posedge aclk)
        !aresetn |=> !program_select_r && !erase_select_r && !margin_select_r
                     && !high_voltage_enable_r && erase_block_size_r == 2'h0)
        else $error("control bits not cleared by reset");

    write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_ctrl && !wdata_r[`FPE_BIT_ERASE] && !prot_hit)
            |=> program_select_r == $past(wdata_r[`FPE_BIT_PROG]) && bvalid_r)
        else $error("program select not written");

endmodule : fpe_flash_ctrl
`default_nettype wire

// ### core/fpe_regs.svh
// Register offsets, field positions, reset values for the flash program/erase control
`ifndef FPE_REGS_SVH
`define FPE_REGS_SVH

`define FPE_AXI_AW        8
`define FPE_OFF_CTRL      8'h00
`define FPE_OFF_STATUS    8'h04
`define FPE_OFF_PROTECT   8'h08

`define FPE_BIT_PROG      0
`define FPE_BIT_ERASE     1
`define FPE_BIT_MARGIN    2
`define FPE_BIT_HV        3
`define FPE_BIT_BLK_LO    4
`define FPE_BIT_BLK_HI    5
`define FPE_BIT_DIV       6
`define FPE_BIT_DIV_SPARE 7

`define FPE_CTRL_RESET    8'h00
`define FPE_PROT_EN_BIT   16
`define FPE_ARR_AW        15
`define FPE_ROW_SHIFT     6
`define FPE_PAGE_SHIFT    3
`define FPE_LAST_ROW      9'h1F8

`define FPE_MASK_FULL     15'h7FFF
`define FPE_MASK_HALF     15'h3FFF
`define FPE_MASK_EIGHT    15'h01FF
`define FPE_MASK_ROW      15'h003F

`define FPE_RESP_OKAY     2'h0
`define FPE_RESP_SLVERR   2'h2

`endif

// ### core/fpe_pkg.sv
// Types and shared decode for the flash program/erase control
package fpe_pkg;
`include "fpe_regs.svh"

    typedef logic [1:0]              fpe_blk_t;
    typedef logic [`FPE_ARR_AW-1:0]  fpe_addr_t;

    // Span of one erase block, as an address mask
    function automatic fpe_addr_t fpe_blk_mask(input fpe_blk_t blk);
        case (blk)
            2'h0:    fpe_blk_mask = `FPE_MASK_FULL;
            2'h1:    fpe_blk_mask = `FPE_MASK_HALF;
            2'h2:    fpe_blk_mask = `FPE_MASK_EIGHT;
            default: fpe_blk_mask = `FPE_MASK_ROW;
        endcase
    endfunction : fpe_blk_mask

endpackage : fpe_pkg

// ### core/fpe_pump_div.sv
// Charge-pump clock divider fed by the sampled PLL VCO clock
`timescale 1ns/1ps
`default_nettype none
module fpe_pump_div
    import fpe_pkg::*;
(
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Control
    input  wire logic pll_vco_clock,
    input  wire logic run,
    input  wire logic pump_clock_divide,
    // Pump clock
    output logic      pump_clk
);
    logic vco_s1_r;
    logic vco_s2_r;
    logic vco_s3_r;
    logic half_r;
    logic pump_r;
    logic vco_rise;

    // VCO runs slower than aclk; two flops before any logic reads it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vco_s1_r <= 1'b0;
            vco_s2_r <= 1'b0;
            vco_s3_r <= 1'b0;
        end else begin
            vco_s1_r <= pll_vco_clock;
            vco_s2_r <= vco_s1_r;
            vco_s3_r <= vco_s2_r;
        end
    end

    assign vco_rise = vco_s2_r && !vco_s3_r;

    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            half_r <= 1'b0;
            pump_r <= 1'b0;
        end else if (vco_rise) begin
            half_r <= ~half_r;
            if (!pump_clock_divide || half_r) begin
                pump_r <= ~pump_r;
            end
        end
    end

    assign pump_clk = pump_r;

    property div2_p;
        @(posedge aclk) disable iff (!aresetn)
        (run && $past(run) && vco_rise && !pump_clock_divide) |=> (pump_r != $past(pump_r));
    endproperty
    div_by_two_a: assert property (div2_p) else $error("pump not toggled in divide by 2");

    property stop_p;
        @(posedge aclk) disable iff (!aresetn)
        !run |=> !pump_r;
    endproperty
    pump_stopped_a: assert property (stop_p) else $error("pump runs without high voltage");

endmodule : fpe_pump_div
`default_nettype wire

// ### core/fpe_blk_latch.sv
// Latches the target address of an erase and decodes the block it selects
`timescale 1ns/1ps
`default_nettype none
module fpe_blk_latch
    import fpe_pkg::*;
(
    // Clock and reset
    input  wire logic      aclk,
    input  wire logic      aresetn,
    // Capture
    input  wire logic      capture,
    input  wire fpe_addr_t addr,
    input  wire fpe_blk_t  blk,
    // Selected block
    output fpe_addr_t      base,
    output fpe_addr_t      mask
);
    fpe_addr_t base_r;
    fpe_addr_t mask_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            base_r <= '0;
            mask_r <= '0;
        end else if (capture) begin
            mask_r <= fpe_blk_mask(blk);
            base_r <= addr & ~fpe_blk_mask(blk);
        end
    end

    assign base = base_r;
    assign mask = mask_r;

    property base_p;
        @(posedge aclk) disable iff (!aresetn)
        capture |=> (base_r == ($past(addr) & ~mask_r)) && ((base_r & mask_r) == '0);
    endproperty
    base_latched_a: assert property (base_p) else $error("erase base not latched");

    property row_p;
        @(posedge aclk) disable iff (!aresetn)
        (capture && blk == 2'h3) |=> (mask_r == 15'h003F);
    endproperty
    row_mask_a: assert property (row_p) else $error("single row mask wrong");

endmodule : fpe_blk_latch
`default_nettype wire

// ### test/fpe_flash_model.sv
// Far-side model: PLL clock feeding the pump, array that counts page loads
`timescale 1ns/1ps
`default_nettype none
module fpe_flash_model (
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Array side
    input  wire logic prog_load,
    output var logic  pll_vco_clock,
    output int        loads
);
    // PLL locked and running before any operation
    initial begin
        pll_vco_clock = 1'b0;
        forever #20 pll_vco_clock = ~pll_vco_clock;
    end

    // One load per eight-byte page program
    always_ff @(posedge aclk) begin
        if (!aresetn) loads <= 0;
        else if (prog_load) loads <= loads + 1;
    end
endmodule : fpe_flash_model
`default_nettype wire

// ### test/flash_program_erase_control_test.sv
// Register-level bench for the flash program/erase control
`timescale 1ns/1ps
`default_nettype none
module flash_program_erase_control_test;
    import fpe_pkg::*;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, arr_wr_valid, pp;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, arr_wr_data;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        high_voltage_array, pump_clk, program_mode, erase_mode, margin_mode;
    logic        erase_armed, prog_load, pll_vco_clock;
    fpe_addr_t   arr_wr_addr, erase_base, erase_mask;
    logic [11:0] prog_page;
    logic [7:0]  prog_data;
    int          err_count, n_tests, loads, n, e;
    fpe_addr_t   mk [4] = '{15'h7FFF, 15'h3FFF, 15'h01FF, 15'h003F};
    logic [7:0]  pv [4] = '{8'h09, 8'h49, 8'hC9, 8'h89};

    fpe_flash_ctrl fpe_flash_ctrl_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .arr_wr_valid, .arr_wr_addr, .arr_wr_data, .pll_vco_clock, .high_voltage_array,
        .pump_clk, .program_mode, .erase_mode, .margin_mode, .erase_armed, .erase_base,
        .erase_mask, .prog_page, .prog_data, .prog_load);
    fpe_flash_model fpe_flash_model_i (.aclk, .aresetn, .prog_load, .pll_vco_clock, .loads);

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    task automatic results;
        $display("errors %0d checks %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_tests++;
        if (g !== x) begin
            err_count++;
            $display("BAD t=%0t got %h exp %h", $time, g, x);
        end
    endtask : chk

    // Valids held until their own ready is sampled
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata; r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd

    task automatic wc(input logic [7:0] v, input logic [7:0] x);
        wr(8'h00, {24'h0, v});
        rd(8'h00);
        chk(d, {24'h0, x});
    endtask : wc

    task automatic aw(input fpe_addr_t a, input logic [7:0] v);
        @(posedge aclk);
        arr_wr_valid <= 1'b1; arr_wr_addr <= a; arr_wr_data <= v;
        @(posedge aclk);
        arr_wr_valid <= 1'b0;
        @(posedge aclk);
        #1;
    endtask : aw

    initial begin
        #200000;
        err_count++;
        results();
    end

    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, arr_wr_valid, s_axi_awaddr, s_axi_araddr, arr_wr_data} = '0;
        s_axi_wdata = '0; s_axi_wstrb = 4'hF; arr_wr_addr = '0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(8'h00); chk(d, 32'h0);
        wc(8'h08, 8'h00);
        wc(8'h04, 8'h04);
        wc(8'h05, 8'h05);
        wc(8'h0D, 8'h09);
        chk(high_voltage_array, 1'b1);
        wc(8'h05, 8'h01);
        wc(8'h03, 8'h01);
        chk({program_mode, erase_mode, margin_mode}, 3'h4);
        aw(15'h0123, 8'hA5);
        chk(prog_page, 12'h024);
        chk(prog_data, 8'hA5);
        chk(loads, 1);
        wc(8'h05, 8'h05);
        // Pump rises over 160 cycles, 16 VCO periods; edge alignment allows one off
        for (int i = 0; i < 4; i++) begin
            wc(pv[i], pv[i]);
            e = pv[i][6] ? 4 : 8;
            n = 0;
            pp = pump_clk;
            repeat (160) begin
                @(posedge aclk);
                if (pump_clk && !pp) n++;
                pp = pump_clk;
            end
            chk((n >= e - 1 && n <= e + 1) ? e : n, e);
        end
        wc(8'h00, 8'h00);
        repeat (4) @(posedge aclk);
        chk({high_voltage_array, pump_clk}, 2'h0);
        for (int b = 0; b < 4; b++) begin
            wc(8'h00, 8'h00); chk(erase_armed, 1'b0);
            wc(8'h02 | 8'(b << 4), 8'h02 | 8'(b << 4));
            aw(15'h4A45, 8'h00);
            chk(erase_mask, mk[b]);
            chk(erase_base, 15'h4A45 & ~mk[b]);
            chk(erase_armed, 1'b1);
            rd(8'h04); chk(d, {17'h00001, 15'h4A45 & ~mk[b]});
        end
        wr(8'h08, 32'h00010100);
        rd(8'h08); chk(d, 32'h00010100);
        aw(15'h4A45, 8'h00);
        rd(8'h00); chk(d, 32'h00000030);
        rd(8'h04); chk(d, 32'h00014A40);
        chk(erase_armed, 1'b0);
        // Lane 0 off: the control byte must not move
        s_axi_wstrb <= 4'hE;
        wr(8'h00, 32'h00000001); chk(r, 2'h0);
        s_axi_wstrb <= 4'hF;
        rd(8'h00); chk(d, 32'h00000030);
        wr(8'h0C, 32'h1); chk(r, 2'h2);
        rd(8'h0C); chk(r, 2'h2);
        results();
    end
endmodule : flash_program_erase_control_test
`default_nettype wire
